// File: verilog/pcq_handler.sv
// Control-plane query handler: gain, time, carrier sense and noise commands over APB.
//
// Behaviour
// [RULE_01] Gain and carrier sense only on powerline.
// [RULE_02] Gain set carries mode, index, medium.
// [RULE_03] Auto mode starts from the set index.
// [RULE_04] Gain step never above six decibels.
// [RULE_05] Top gain reaches at least 21 dB.
// [RULE_06] Gain confirm returns mode, index, medium.
// [RULE_07] Time reported in 10 us units, 20 bits.
// [RULE_08] Carrier from preamble then valid header.
// [RULE_09] Carrier-found flag is one when present.
// [RULE_10] Signal index: 70 dBuV base, 2 dB steps.
// [RULE_11] No carrier gives zero time.
// [RULE_12] Header pending flag reports header end.
// [RULE_13] Decoded header gives absolute frame end.
// [RULE_14] Noise floor from a running estimator.
// [RULE_15] Noise index: 50 dBuV base, 3 dB steps.
// [RULE_16] Every command and confirm carries medium.
// [RULE_17] One confirm per command, in order.
`timescale 1ns/1ps
module pcq_handler #(
  parameter int GAIN_LEVELS = 8,
  parameter int MIN_GAIN_DB = 0,
  parameter int GAIN_STEP_DB = 3,
  parameter logic [19:0] HDR_UNITS = 20'h00007
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_preamble_det,
  input wire logic rx_header_ok,
  input wire logic rx_header_bad,
  input wire logic [19:0] rx_frame_len,
  input wire logic rx_frame_done,
  input wire logic [7:0] rx_signal_dbuv,
  input wire logic [7:0] rx_noise_dbuv,
  input wire logic agc_gain_up,
  input wire logic agc_gain_down,
  output logic [3:0] rx_gain_index,
  output logic rx_gain_manual
);
  localparam int DIV_W = $clog2(pcq_pkg::TICK_CYCLES);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(pcq_pkg::TICK_CYCLES - 1);
  localparam logic [3:0] GAIN_TOP = 4'(GAIN_LEVELS - 1); // RULE_05

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic tick;
    logic [19:0] now;
    pcq_pkg::pcq_cs_t cs;
    logic [19:0] hdr_end;
    logic [19:0] frame_end;
    logic [7:0] noise_avg;
    logic gain_mode;
    logic [3:0] gain_idx;
    logic [31:0] cmd_last;
    logic conf_valid;
    logic conf_unsup;
    logic [2:0] conf_op;
    logic conf_flag;
    logic conf_hdr;
    logic [3:0] conf_idx;
    logic [7:0] conf_med;
    logic [19:0] conf_time;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pcq_state_t;

  pcq_state_t s_reg;
  pcq_state_t s_next;

  // Maps a level in dBuV to a 16-step index: index k covers up to base + k*step.
  function automatic logic [3:0] level_idx(input logic [7:0] x, input logic [7:0] base, input logic [7:0] step);
    logic [7:0] over;
    logic [8:0] q;
    over = (x > base) ? 8'(x - base) : 8'h00;
    q = 9'((9'(over) + 9'(step) - 9'h001) / 9'(step));
    return (q > 9'h00F) ? 4'hF : q[3:0];
  endfunction

  logic acc_first;
  logic complete;
  logic cmd_done;
  logic [2:0] cmd_op;
  logic cmd_rf;
  logic [3:0] cmd_gain;
  logic signed [9:0] noise_diff;

  assign acc_first = psel && penable && !s_reg.pready;
  assign complete = psel && penable && s_reg.pready;
  assign cmd_done = complete && pwrite && !s_reg.pslverr && (paddr == pcq_pkg::ADDR_CMD);
  assign cmd_op = pwdata[pcq_pkg::CMD_OP_LSB +: 3];
  assign cmd_rf = pwdata[pcq_pkg::CMD_MED_LSB + pcq_pkg::MEDIUM_RF_BIT];
  assign cmd_gain = pwdata[pcq_pkg::CMD_GAIN_LSB +: 4];
  assign noise_diff = $signed({2'b00, rx_noise_dbuv}) - $signed({2'b00, s_reg.noise_avg});

  always_comb
  begin
    s_next = s_reg;
    // Layer time advances once every 10 us.
    s_next.tick = (s_reg.div == DIV_LAST);
    s_next.div = s_next.tick ? '0 : DIV_W'(s_reg.div + 1'b1);
    if (s_reg.tick)
    begin
      s_next.now = 20'(s_reg.now + 20'h00001); // RULE_07
    end
    // Averaging only outside frames keeps the estimate free of signal power.
    if (s_reg.tick && (s_reg.cs == pcq_pkg::CS_IDLE))
    begin
      s_next.noise_avg = 8'($signed({2'b00, s_reg.noise_avg}) + (noise_diff >>> 2)); // RULE_14
    end
    // Carrier sense tracks preamble first, then the header verdict.
    case (s_reg.cs)
      pcq_pkg::CS_IDLE:
      begin
        if (rx_preamble_det)
        begin
          s_next.cs = pcq_pkg::CS_HDR; // RULE_08
          s_next.hdr_end = 20'(s_reg.now + HDR_UNITS);
        end
      end
      pcq_pkg::CS_HDR:
      begin
        if (rx_header_ok)
        begin
          s_next.cs = pcq_pkg::CS_FRAME; // RULE_08
          s_next.frame_end = 20'(s_reg.now + rx_frame_len); // RULE_13
        end
        else if (rx_header_bad)
        begin
          s_next.cs = pcq_pkg::CS_IDLE;
        end
      end
      pcq_pkg::CS_FRAME:
      begin
        if (rx_frame_done || (s_reg.tick && (s_reg.now == s_reg.frame_end)))
        begin
          s_next.cs = pcq_pkg::CS_IDLE;
        end
      end
      default:
      begin
        s_next.cs = pcq_pkg::CS_IDLE;
      end
    endcase
    // In auto mode the loop walks the gain within the implemented range.
    if (s_reg.gain_mode == pcq_pkg::MODE_AUTO)
    begin
      if (agc_gain_up && (s_reg.gain_idx < GAIN_TOP))
      begin
        s_next.gain_idx = 4'(s_reg.gain_idx + 4'h1); // RULE_03
      end
      else if (agc_gain_down && (s_reg.gain_idx != 4'h0))
      begin
        s_next.gain_idx = 4'(s_reg.gain_idx - 4'h1);
      end
    end
    // APB: the answer is prepared in the first access cycle, pready follows one cycle later.
    s_next.pready = acc_first;
    if (acc_first)
    begin
      s_next.prdata = 32'h0000_0000;
      s_next.pslverr = 1'b0;
      if (paddr == pcq_pkg::ADDR_CMD)
      begin
        s_next.prdata = s_reg.cmd_last;
        s_next.pslverr = pwrite && s_reg.conf_valid; // RULE_17
      end
      else if (paddr == pcq_pkg::ADDR_CONF)
      begin
        s_next.prdata[pcq_pkg::CONF_VALID_BIT] = s_reg.conf_valid;
        s_next.prdata[pcq_pkg::CONF_UNSUP_BIT] = s_reg.conf_unsup;
        s_next.prdata[pcq_pkg::CONF_OP_LSB +: 3] = s_reg.conf_op;
        s_next.prdata[pcq_pkg::CONF_FLAG_BIT] = s_reg.conf_flag;
        s_next.prdata[pcq_pkg::CONF_HDR_BIT] = s_reg.conf_hdr;
        s_next.prdata[pcq_pkg::CONF_IDX_LSB +: 4] = s_reg.conf_idx;
        s_next.prdata[pcq_pkg::CONF_MED_LSB +: 8] = s_reg.conf_med;
      end
      else if (paddr == pcq_pkg::ADDR_CONF_TIME)
      begin
        s_next.prdata[19:0] = s_reg.conf_time;
        s_next.pslverr = pwrite;
      end
      else if (paddr == pcq_pkg::ADDR_STATUS)
      begin
        s_next.prdata[19:0] = s_reg.now;
        s_next.prdata[pcq_pkg::STAT_CARRIER_BIT] = (s_reg.cs != pcq_pkg::CS_IDLE);
        s_next.prdata[pcq_pkg::STAT_HDR_BIT] = (s_reg.cs == pcq_pkg::CS_HDR);
        s_next.prdata[pcq_pkg::STAT_MODE_BIT] = s_reg.gain_mode;
        s_next.prdata[pcq_pkg::STAT_GAIN_LSB +: 4] = s_reg.gain_idx;
        s_next.pslverr = pwrite;
      end
      else
      begin
        s_next.pslverr = 1'b1;
      end
    end
    // Popping the confirm: write one to the valid bit.
    if (complete && pwrite && (paddr == pcq_pkg::ADDR_CONF) && pwdata[pcq_pkg::CONF_VALID_BIT])
    begin
      s_next.conf_valid = 1'b0;
    end
    // A command is refused while a confirm is unread, so confirms never overtake or drop.
    if (cmd_done)
    begin
      s_next.cmd_last = pwdata;
      s_next.conf_valid = 1'b1; // RULE_17
      s_next.conf_op = cmd_op;
      s_next.conf_med = pwdata[pcq_pkg::CMD_MED_LSB +: 8]; // RULE_16
      s_next.conf_unsup = 1'b0;
      s_next.conf_flag = 1'b0;
      s_next.conf_hdr = 1'b0;
      s_next.conf_idx = 4'h0;
      s_next.conf_time = 20'h00000;
      case (cmd_op)
        pcq_pkg::OP_GAIN_SET:
        begin
          if (cmd_rf)
          begin
            s_next.conf_unsup = 1'b1; // RULE_01
          end
          else
          begin
            s_next.gain_mode = pwdata[pcq_pkg::CMD_MODE_BIT]; // RULE_02
            s_next.gain_idx = (cmd_gain > GAIN_TOP) ? GAIN_TOP : cmd_gain; // RULE_03
            s_next.conf_flag = pwdata[pcq_pkg::CMD_MODE_BIT]; // RULE_06
            s_next.conf_idx = s_next.gain_idx;
          end
        end
        pcq_pkg::OP_GAIN_GET:
        begin
          if (cmd_rf)
          begin
            s_next.conf_unsup = 1'b1; // RULE_01
          end
          else
          begin
            s_next.conf_flag = s_reg.gain_mode; // RULE_06
            s_next.conf_idx = s_reg.gain_idx;
          end
        end
        pcq_pkg::OP_TIME_GET:
        begin
          s_next.conf_time = s_reg.now; // RULE_07
        end
        pcq_pkg::OP_CS_GET:
        begin
          if (cmd_rf)
          begin
            s_next.conf_unsup = 1'b1; // RULE_01
          end
          else if (s_reg.cs == pcq_pkg::CS_HDR)
          begin
            s_next.conf_flag = 1'b1; // RULE_09
            s_next.conf_hdr = 1'b1; // RULE_12
            s_next.conf_time = s_reg.hdr_end;
            s_next.conf_idx = level_idx(rx_signal_dbuv, pcq_pkg::RSSI_BASE_DBUV, pcq_pkg::RSSI_STEP_DB); // RULE_10
          end
          else if (s_reg.cs == pcq_pkg::CS_FRAME)
          begin
            s_next.conf_flag = 1'b1; // RULE_09
            s_next.conf_time = s_reg.frame_end; // RULE_13
            s_next.conf_idx = level_idx(rx_signal_dbuv, pcq_pkg::RSSI_BASE_DBUV, pcq_pkg::RSSI_STEP_DB); // RULE_10
          end
          else
          begin
            s_next.conf_time = 20'h00000; // RULE_11
          end
        end
        pcq_pkg::OP_NOISE_GET:
        begin
          s_next.conf_idx = level_idx(s_reg.noise_avg, pcq_pkg::NOISE_BASE_DBUV, pcq_pkg::NOISE_STEP_DB); // RULE_15
        end
        default:
        begin
          s_next.conf_unsup = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s_reg <= '0;
      s_reg.cs <= pcq_pkg::CS_IDLE;
      s_reg.gain_mode <= pcq_pkg::MODE_AUTO;
      s_reg.gain_idx <= pcq_pkg::GAIN_RESET_IDX;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign rx_gain_index = s_reg.gain_idx;
  assign rx_gain_manual = s_reg.gain_mode;

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_cs_taken;
    cmd_done && (cmd_op == pcq_pkg::OP_CS_GET) && !cmd_rf;
  endsequence
  sequence s_gain_set_taken;
    cmd_done && (cmd_op == pcq_pkg::OP_GAIN_SET) && !cmd_rf && (cmd_gain <= GAIN_TOP);
  endsequence

  chk_one_confirm: assert property (cmd_done |=> s_reg.conf_valid && (s_reg.conf_op == $past(cmd_op))) // RULE_17
    else $error("command not confirmed");
  chk_busy_refuse: assert property (s_reg.conf_valid && acc_first && pwrite // RULE_17
    && (paddr == pcq_pkg::ADDR_CMD)
    |=> s_reg.pready && s_reg.pslverr ##1 (s_reg.conf_op == $past(s_reg.conf_op, 2)))
    else $error("command taken over unread confirm");
  chk_rf_refused: assert property (cmd_done && cmd_rf && (cmd_op == pcq_pkg::OP_CS_GET) |=> s_reg.conf_unsup) // RULE_01
    else $error("radio carrier sense not refused");
  chk_gain_echo: assert property (s_gain_set_taken |=> (s_reg.conf_flag == $past(pwdata[3])) // RULE_06
    && (s_reg.conf_idx == $past(cmd_gain)) && (rx_gain_index == s_reg.conf_idx)
    && (s_reg.conf_med == $past(pwdata[23:16])))
    else $error("gain confirm mismatch");
  chk_gain_range: assert property ((s_reg.gain_idx <= GAIN_TOP) // RULE_04 RULE_05
    && (GAIN_STEP_DB <= pcq_pkg::GAIN_STEP_MAX_DB)
    && (MIN_GAIN_DB + (GAIN_LEVELS - 1) * GAIN_STEP_DB >= pcq_pkg::GAIN_TOP_MIN_DB))
    else $error("gain outside allowed range");
  chk_time_tick: assert property (s_reg.tick |=> (s_reg.now == 20'($past(s_reg.now) + 20'h00001)) // RULE_07
    ##0 (!s_reg.tick [*8]))
    else $error("layer time step wrong");
  chk_idle_zero: assert property (s_cs_taken and (s_reg.cs == pcq_pkg::CS_IDLE) // RULE_11
    |=> !s_reg.conf_flag && !s_reg.conf_hdr && (s_reg.conf_time == 20'h00000))
    else $error("idle carrier confirm not zero");
  chk_hdr_pending: assert property (s_cs_taken and (s_reg.cs == pcq_pkg::CS_HDR) // RULE_12
    |=> s_reg.conf_flag && s_reg.conf_hdr && (s_reg.conf_time == $past(s_reg.hdr_end)))
    else $error("header pending confirm wrong");
  chk_frame_end: assert property ((s_reg.cs == pcq_pkg::CS_HDR) && rx_header_ok // RULE_13
    |=> (s_reg.cs == pcq_pkg::CS_FRAME) && (s_reg.frame_end == 20'($past(s_reg.now) + $past(rx_frame_len))))
    else $error("frame end not absolute");
  chk_rssi_floor: assert property (s_cs_taken and (s_reg.cs != pcq_pkg::CS_IDLE) // RULE_10
    and (rx_signal_dbuv <= 8'h46) |=> s_reg.conf_flag && (s_reg.conf_idx == 4'h0))
    else $error("signal index floor wrong");
  chk_noise_top: assert property (cmd_done && (cmd_op == pcq_pkg::OP_NOISE_GET) // RULE_15
    && (s_reg.noise_avg > 8'h5C) |=> s_reg.conf_idx == 4'hF)
    else $error("noise index top wrong");
endmodule

// File: verilog/pcq_pkg.sv
// Constants and types for the control-plane query handler.
package pcq_pkg;
  // Register byte offsets.
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_CONF = 8'h04;
  localparam logic [7:0] ADDR_CONF_TIME = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  // Command opcodes.
  localparam logic [2:0] OP_GAIN_SET = 3'h1;
  localparam logic [2:0] OP_GAIN_GET = 3'h2;
  localparam logic [2:0] OP_TIME_GET = 3'h3;
  localparam logic [2:0] OP_CS_GET = 3'h4;
  localparam logic [2:0] OP_NOISE_GET = 3'h5;
  // Field positions.
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_MODE_BIT = 3;
  localparam int CMD_GAIN_LSB = 8;
  localparam int CMD_MED_LSB = 16;
  localparam int CONF_VALID_BIT = 0;
  localparam int CONF_UNSUP_BIT = 1;
  localparam int CONF_OP_LSB = 2;
  localparam int CONF_FLAG_BIT = 5;
  localparam int CONF_HDR_BIT = 6;
  localparam int CONF_IDX_LSB = 8;
  localparam int CONF_MED_LSB = 16;
  localparam int STAT_CARRIER_BIT = 20;
  localparam int STAT_HDR_BIT = 21;
  localparam int STAT_MODE_BIT = 22;
  localparam int STAT_GAIN_LSB = 24;
  localparam int MEDIUM_RF_BIT = 7;
  // Modes and reset values.
  localparam logic MODE_AUTO = 1'b0;
  localparam logic MODE_MANUAL = 1'b1;
  localparam logic [3:0] GAIN_RESET_IDX = 4'h0;
  // Time base.
  localparam int TIME_W = 20;
  localparam int TIME_UNIT_NS = 10000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_CYCLES = TIME_UNIT_NS / CLK_PERIOD_NS;
  // Level index scales.
  localparam logic [7:0] RSSI_BASE_DBUV = 8'h46;
  localparam logic [7:0] RSSI_STEP_DB = 8'h02;
  localparam logic [7:0] NOISE_BASE_DBUV = 8'h32;
  localparam logic [7:0] NOISE_STEP_DB = 8'h03;
  localparam int GAIN_STEP_MAX_DB = 6;
  localparam int GAIN_TOP_MIN_DB = 21;
  typedef enum logic [2:0] {CS_IDLE = 3'h1, CS_HDR = 3'h2, CS_FRAME = 3'h4} pcq_cs_t;
endpackage

// File: verif/pcq_rx_model.sv
// Receiver front-end model that drives the frame and gain-step pulses.
`timescale 1ns/1ps
module pcq_rx_model (
  input wire logic clk,
  output logic pre,
  output logic hok,
  output logic hbad,
  output logic [19:0] flen,
  output logic fdone,
  output logic gup,
  output logic gdn
);
  initial
  begin
    {pre, hok, hbad, fdone, gup, gdn} = '0;
    flen = 20'hFFFFF;
  end
  // Length is only meaningful with the header pulse, so it is scrambled otherwise.
  task pulse(input int w, input logic [19:0] len);
    @(posedge clk);
    case (w)
      0: pre <= 1'b1;
      1: hok <= 1'b1;
      2: hbad <= 1'b1;
      3: fdone <= 1'b1;
      4: gup <= 1'b1;
      default: gdn <= 1'b1;
    endcase
    flen <= len;
    @(posedge clk);
    {pre, hok, hbad, fdone, gup, gdn} <= '0;
    flen <= ~len;
  endtask
endmodule

// File: verif/pcq_handler_tb.sv
// Self-checking bench for the query handler with an APB master and a confirm model.
`timescale 1ns/1ps
module pcq_handler_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd, rnd;
  logic pready, pslverr, err, pre, hok, hbad, fdone, gup, gdn, gman;
  logic [19:0] flen;
  logic [7:0] sig = 8'h46;
  logic [7:0] noise = 8'h32;
  logic [3:0] gidx;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  int ul[5] = '{1, 4, 0, 6, 7};
  logic [31:0] q[$];
  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= rst_b ? cyc + 1 : 0;
  pcq_handler dut_u (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_preamble_det(pre),
    .rx_header_ok(hok), .rx_header_bad(hbad), .rx_frame_len(flen), .rx_frame_done(fdone),
    .rx_signal_dbuv(sig), .rx_noise_dbuv(noise), .agc_gain_up(gup), .agc_gain_down(gdn),
    .rx_gain_index(gidx), .rx_gain_manual(gman));
  pcq_rx_model rx_u (.clk(clk), .pre(pre), .hok(hok), .hbad(hbad), .flen(flen), .fdone(fdone), .gup(gup),
    .gdn(gdn));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] cw(int op, int f, int h, int idx, logic [7:0] med);
    return 32'(1 | op << pcq_pkg::CONF_OP_LSB | f << pcq_pkg::CONF_FLAG_BIT | h << pcq_pkg::CONF_HDR_BIT
      | idx << pcq_pkg::CONF_IDX_LSB) | {8'h00, med, 16'h0000};
  endfunction
  function automatic logic [31:0] cmd(int op, int md, int g, logic [7:0] med);
    return 32'(op | md << pcq_pkg::CMD_MODE_BIT | g << pcq_pkg::CMD_GAIN_LSB) | {8'h00, med, 16'h0000};
  endfunction
  function automatic int lvl(int x, int base, int step);
    int k;
    k = x <= base ? 0 : (x - base + step - 1) / step;
    return k > 15 ? 15 : k;
  endfunction
  task test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task chk_in(input logic [31:0] g, input int lo, input int hi);
    cmp_count++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, lo);
    end
  endtask
  // The request stands until pready is seen high at a rising edge; data and error are taken at that edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1)
    begin
      n_fail++;
      test_done;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task run(input logic [31:0] c, input logic [31:0] m, output logic [31:0] tm);
    logic [31:0] e;
    e = q.pop_front();
    apb(1'b1, pcq_pkg::ADDR_CMD, c);
    chk(32'(err), 32'h0);
    apb(1'b0, pcq_pkg::ADDR_CONF, 32'h0);
    chk(rd & m, e & m);
    apb(1'b0, pcq_pkg::ADDR_CONF_TIME, 32'h0);
    tm = rd;
    apb(1'b1, pcq_pkg::ADDR_CONF, 32'h1);
  endtask
  task now(output int n);
    apb(1'b0, pcq_pkg::ADDR_STATUS, 32'h0);
    n = rd[19:0];
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    n_fail++;
    test_done;
  end
  initial
  begin
    int i, n0, n1, md, g, ge, a, x, len;
    logic [31:0] tm;
    logic [7:0] med;
    rnd = nxt(32'hA721);
    noise = 8'(40 + rnd % 70);
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, pcq_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, pcq_pkg::ADDR_CONF, 32'h0);
    chk(rd | 32'(gidx) | 32'(gman), 32'h0);
    $display("reset test done");
    for (i = 0; i < 8; i++)
    begin
      rnd = nxt(rnd);
      md = i % 2;
      g = i < 2 ? 0 : i < 4 ? 15 : rnd % 8;
      ge = g > 7 ? 7 : g;
      med = {1'b0, rnd[14:8]};
      q.push_back(cw(1, md, 0, ge, med));
      run(cmd(1, md, g, med), 32'h00FF0F7F, tm);
      chk(32'({gman, gidx}), 32'(md << 4 | ge));
      rx_u.pulse(i % 4 < 2 ? 4 : 5, 20'h0);
      ge = md ? ge : i % 4 < 2 ? (ge == 7 ? 7 : ge + 1) : (ge == 0 ? 0 : ge - 1);
      q.push_back(cw(2, md, 0, ge, med));
      run(cmd(2, 0, 0, med), 32'h00FF0F7F, tm);
    end
    $display("gain test done");
    for (i = 0; i < 5; i++)
    begin
      med = {i < 2, rnd[6:0]};
      q.push_back(32'(3 + ul[i] * 4) | {8'h00, med, 16'h0000});
      run(cmd(ul[i], 1, 2, med), 32'h00FF001F, tm);
      chk(32'({gman, gidx}), 32'(md << 4 | ge));
    end
    apb(1'b1, pcq_pkg::ADDR_CMD, cmd(3, 0, 0, 8'h01));
    apb(1'b1, pcq_pkg::ADDR_CMD, cmd(5, 0, 0, 8'h02));
    chk(32'(err), 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, pcq_pkg::ADDR_STATUS, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b0, pcq_pkg::ADDR_CONF, 32'h0);
    chk(rd & 32'h00FF001D, 32'h0001000D);
    apb(1'b0, pcq_pkg::ADDR_CMD, 32'h0);
    chk(rd, cmd(3, 0, 0, 8'h01));
    apb(1'b1, pcq_pkg::ADDR_CONF, 32'h1);
    $display("refusal test done");
    repeat (4000) @(posedge clk);
    q.push_back(cw(3, 0, 0, 0, 8'h05));
    run(cmd(3, 0, 0, 8'h05), 32'h00FF001D, tm);
    chk_in(tm, cyc / 2000 - 1, cyc / 2000 + 1);
    q.push_back(cw(4, 0, 0, 0, 8'h06));
    run(cmd(4, 0, 0, 8'h06), 32'h00FF0F7F, tm);
    chk(tm, 32'h0);
    for (i = 0; i < 3; i++)
    begin
      rnd = nxt(rnd);
      sig <= rnd[7:0];
      med = {1'b0, rnd[14:8]};
      now(n0);
      rx_u.pulse(0, 20'h0);
      now(n1);
      chk(32'(rd[21:20]), 32'h3);
      q.push_back(cw(4, 1, 1, lvl(rnd[7:0], 70, 2), med));
      run(cmd(4, 0, 0, med), 32'h00FF0F7F, tm);
      chk_in(tm, n0 + 7, n1 + 7);
      if (i == 1)
        rx_u.pulse(2, 20'h0);
      else
      begin
        len = i == 2 ? 1 : 20 + rnd[20:16];
        now(n0);
        rx_u.pulse(1, 20'(len));
        now(n1);
        chk(32'(rd[21:20]), 32'h1);
        q.push_back(cw(4, 1, 0, lvl(rnd[7:0], 70, 2), med));
        run(cmd(4, 0, 0, med), 32'h00FF0F7F, tm);
        chk_in(tm, n0 + len, n1 + len);
        if (i == 0)
          rx_u.pulse(3, 20'h0);
        else
          repeat (6000) @(posedge clk);
      end
      q.push_back(cw(4, 0, 0, 0, med));
      run(cmd(4, 0, 0, med), 32'h00FF0F7F, tm);
      chk(tm, 32'h0);
    end
    $display("carrier test done");
    while (cyc < 60000)
      @(posedge clk);
    a = 0;
    x = noise;
    repeat (60) a += (x - a) >>> 2;
    for (i = 0; i < 2; i++)
    begin
      med = {i[0], rnd[6:0]};
      q.push_back(cw(5, 0, 0, lvl(a, 50, 3), med));
      run(cmd(5, 0, 0, med), 32'h00FF0F1F, tm);
    end
    $display("noise test done");
    test_done;
  end
endmodule
